// ==== core/imu_acc_if.sv ====
// Sample and window-sum signals between formatter core and accumulator
`timescale 1ns/1ns
interface imu_acc_if #(parameter int SUM_W = 26);
   logic smp;
   logic take;
   logic done;
   logic signed [23:0] acc_val;
   logic signed [23:0] vel_val;
   logic signed [23:0] vel_int;
   logic signed [SUM_W-1:0] acc_sum;
   logic signed [SUM_W-1:0] vel_sum;
   modport core (output smp, take, acc_val, vel_val,
                 input done, acc_sum, vel_sum, vel_int);
   modport accum (input smp, take, acc_val, vel_val,
                  output done, acc_sum, vel_sum, vel_int);
endinterface : imu_acc_if

// ==== core/imu_accum.sv ====
// Window sums since the last take strobe and free-running velocity integral
`timescale 1ns/1ns
module imu_accum
   import imu_fmt_pkg::*;
#(
   parameter int SUM_W = 26
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Core side
   imu_acc_if.accum acc
);
   logic signed [SUM_W-1:0] sa_r, sa_nxt, sv_r, sv_nxt;
   logic signed [SUM_W-1:0] ha_r, ha_nxt, hv_r, hv_nxt;
   logic signed [INCL_W-1:0] int_r, int_nxt;
   logic done_r, done_nxt;

   always_comb begin
      sa_nxt = sa_r;
      sv_nxt = sv_r;
      ha_nxt = ha_r;
      hv_nxt = hv_r;
      int_nxt = int_r;
      done_nxt = 1'b0;
      if (acc.smp) begin
         // 24-bit integral wraps on its own, no flag raised
         int_nxt = int_r + acc.vel_val;
         if (acc.take) begin
            // The current sample closes the window; next one opens it
            ha_nxt = sa_r + SUM_W'(acc.acc_val);
            hv_nxt = sv_r + SUM_W'(acc.vel_val);
            sa_nxt = '0;
            sv_nxt = '0;
            done_nxt = 1'b1;
         end else begin
            sa_nxt = sa_r + SUM_W'(acc.acc_val);
            sv_nxt = sv_r + SUM_W'(acc.vel_val);
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sa_r <= '0;
         sv_r <= '0;
         ha_r <= '0;
         hv_r <= '0;
         int_r <= '0;
         done_r <= 1'b0;
      end else begin
         sa_r <= sa_nxt;
         sv_r <= sv_nxt;
         ha_r <= ha_nxt;
         hv_r <= hv_nxt;
         int_r <= int_nxt;
         done_r <= done_nxt;
      end
   end

   assign acc.done = done_r;
   assign acc.acc_sum = ha_r;
   assign acc.vel_sum = hv_r;
   assign acc.vel_int = int_r;
endmodule : imu_accum

// ==== core/imu_fmt_pkg.sv ====
// Constants and types shared by the output formatter and its accumulator
package imu_fmt_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int SAMPLE_RATE_SPS = 2000;
   localparam int SAMPLE_PERIOD_NS = 1000000000 / SAMPLE_RATE_SPS;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int INIT_TIME_NS = 1000;
   localparam int INIT_CYCLES =
      (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RATE_DIV_DEF = 4;
   localparam int INCL_W = 24;
   localparam int TEMP_W = 16;
   localparam int LAT_W = 16;
   localparam int CNT_W = 8;
   localparam int INIT_CNT_W = 16;
   // Trim in 2^-22 g to velocity per sample in 2^-25 m/s, Q16 factor
   localparam int TRIM_VEL_Q16 = 2571;
   localparam int TRIM_VEL_SHIFT = 16;
   localparam logic [INCL_W-1:0] ZERO_FIELD = 24'h000000;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

   typedef enum logic [1:0] {
      UNIT_ACCEL = 2'h0,
      UNIT_INCR = 2'h1,
      UNIT_AVG = 2'h2,
      UNIT_INTEG = 2'h3
   } unit_type;

   typedef enum logic [3:0] {
      MODE_INIT = 4'h1,
      MODE_NORMAL = 4'h2,
      MODE_SERVICE = 4'h4,
      MODE_TRIM = 4'h8
   } mode_type;
endpackage : imu_fmt_pkg

// ==== core/imu_format_core.sv ====
// Inclinometer field formatting, trim offset and operating mode control
`timescale 1ns/1ns
// Contract
// - Incremental velocity: 24-bit two's complement, bit 0 is 2^-25 m/s.
// - Average mode sends the mean of all samples since last transmission; code sends the mean of the last RATE_DIV samples only.
// - Integrated velocity sums from reset, wraps silently at 0.25 m/s.
// - Temperature is 16-bit signed, LSB 2^-8 degC, high byte first.
// - Unsigned 8-bit counter counts every internal sample, wraps silently.
// - Latency is unsigned 16-bit microseconds, high byte first.
// - Current trim offset is added to each compensated value sent.
// - Trim offset is held in g even in incremental or integrated units.
// - Entering service mode triggers the configuration information reply.
// - Service mode keeps measuring but sends no datagrams.
// - Service mode offers a single-shot measurement on request.
// - External reset during service mode goes to init, reloading config.
// - Service exit picks init or normal; normal keeps unsaved settings.
// - Trim entry command stops datagrams and sends an acknowledge.
// - Trim mode keeps sampling and accepts per-axis adjust or reset.
// - Acceleration and average are 24-bit, raw over 2^22 gives g.
// - Leaving trim mode returns to normal and resumes datagrams.
module imu_format_core
   import imu_fmt_pkg::*;
#(
   parameter int SAMPLE_DIV = SAMPLE_CYCLES,
   parameter int RATE_DIV = RATE_DIV_DEF,
   parameter int INIT_CNT = INIT_CYCLES
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Compensated measurement inputs
   input wire logic signed [INCL_W-1:0] accel_in,
   input wire logic signed [INCL_W-1:0] incr_vel_in,
   input wire logic signed [TEMP_W-1:0] temp_in,
   input wire logic [LAT_W-1:0] latency_in,
   input wire logic [1:0] unit_sel_in,
   // Decoded commands, one-cycle pulses
   input wire logic trim_mode_entry_command_in,
   input wire logic trim_mode_exit_in,
   input wire logic maintenance_entry_command_in,
   input wire logic service_exit_in,
   input wire logic service_exit_normal_in,
   input wire logic single_shot_in,
   input wire logic trim_write_in,
   input wire logic trim_clear_in,
   input wire logic signed [INCL_W-1:0] trim_value_in,
   // Formatted fields, high byte first is bits [23:16] / [15:8]
   output logic [INCL_W-1:0] incl_field_out,
   output logic [TEMP_W-1:0] temp_field_out,
   output logic [LAT_W-1:0] latency_field_out,
   output logic [CNT_W-1:0] counter_out,
   output logic datagram_valid_out,
   output logic shot_valid_out,
   // Mode and mode events
   output logic [3:0] mode_out,
   output logic info_reply_out,
   output logic trim_ack_out,
   output logic cfg_reload_out
);
   localparam int LOG2_RATE = $clog2(RATE_DIV);
   localparam int SUM_W = INCL_W + LOG2_RATE + 1;
   localparam int SDIV_W = $clog2(SAMPLE_DIV);
   localparam int RCNT_W = LOG2_RATE + 1;

   // Refuse settings the counters and the shift-based mean cannot serve
   if (RATE_DIV < 1 || RATE_DIV > 256 ||
      (1 << LOG2_RATE) != RATE_DIV) begin : g_bad_rate
      $error("RATE_DIV must be a power of two from 1 to 256");
   end
   if (SAMPLE_DIV < 2) begin : g_bad_sdiv
      $error("SAMPLE_DIV must be at least 2");
   end
   if (INIT_CNT < 1 || INIT_CNT >= (1 << INIT_CNT_W)) begin : g_bad_init
      $error("INIT_CNT out of range");
   end

   // Trim in g converted to velocity per sample in 2^-25 m/s
   function automatic logic signed [INCL_W-1:0] trim_to_vel(
      input logic signed [INCL_W-1:0] trim);
      logic signed [INCL_W+17:0] prod;
      prod = (INCL_W + 18)'(trim) * (INCL_W + 18)'(TRIM_VEL_Q16);
      return prod[TRIM_VEL_SHIFT +: INCL_W];
   endfunction : trim_to_vel

   imu_acc_if #(.SUM_W(SUM_W)) acc ();

   imu_accum #(.SUM_W(SUM_W)) u_accum (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .acc(acc.accum)
   );

   mode_type mode_r, mode_nxt;
   logic [INIT_CNT_W-1:0] init_r, init_nxt;
   logic info_r, info_nxt, ack_r, ack_nxt, reload_r, reload_nxt;

   logic [SDIV_W-1:0] sdiv_r, sdiv_nxt;
   logic [RCNT_W-1:0] rcnt_r, rcnt_nxt;
   logic smp_r, smp_nxt, take_r, take_nxt;
   logic signed [INCL_W-1:0] trim_r, trim_nxt;
   logic signed [INCL_W-1:0] acc_r, acc_nxt, vel_r, vel_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;

   logic [INCL_W-1:0] incl_r, incl_nxt;
   logic [TEMP_W-1:0] temp_r, temp_nxt;
   logic [LAT_W-1:0] lat_r, lat_nxt;
   logic dg_r, dg_nxt, shot_r, shot_nxt;
   logic signed [SUM_W-1:0] avg;

   // Mode machine
   always_comb begin
      mode_nxt = mode_r;
      init_nxt = init_r;
      info_nxt = 1'b0;
      ack_nxt = 1'b0;
      reload_nxt = 1'b0;
      case (mode_r)
         MODE_INIT: begin
            // Flash reload requested once per init entry, also by reset
            reload_nxt = (init_r == '0);
            init_nxt = init_r + 1'b1;
            if (init_r == INIT_CNT_W'(INIT_CNT - 1)) begin
               mode_nxt = MODE_NORMAL;
            end
         end
         MODE_NORMAL: begin
            if (maintenance_entry_command_in) begin
               mode_nxt = MODE_SERVICE;
               info_nxt = 1'b1;
            end else if (trim_mode_entry_command_in) begin
               mode_nxt = MODE_TRIM;
               ack_nxt = 1'b1;
            end
         end
         MODE_SERVICE: begin
            if (service_exit_in) begin
               // Exit to normal keeps live settings, no reload
               if (service_exit_normal_in) begin
                  mode_nxt = MODE_NORMAL;
               end else begin
                  mode_nxt = MODE_INIT;
                  init_nxt = '0;
               end
            end
         end
         MODE_TRIM: begin
            if (trim_mode_exit_in) begin
               mode_nxt = MODE_NORMAL;
            end
         end
         default: begin
            mode_nxt = MODE_INIT;
            init_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mode_r <= MODE_INIT;
         init_r <= '0;
         info_r <= 1'b0;
         ack_r <= 1'b0;
         reload_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         init_r <= init_nxt;
         info_r <= info_nxt;
         ack_r <= ack_nxt;
         reload_r <= reload_nxt;
      end
   end

   // Sampling, trim addition and window control run in every mode; trim writes only in trim or service mode
   always_comb begin
      sdiv_nxt = sdiv_r + 1'b1;
      smp_nxt = 1'b0;
      take_nxt = 1'b0;
      rcnt_nxt = rcnt_r;
      cnt_nxt = cnt_r;
      acc_nxt = acc_r;
      vel_nxt = vel_r;
      trim_nxt = trim_r;
      if (sdiv_r == SDIV_W'(SAMPLE_DIV - 1)) begin
         sdiv_nxt = '0;
         smp_nxt = 1'b1;
         cnt_nxt = cnt_r + 1'b1;
         // Trim added after compensation, velocity via g conversion
         acc_nxt = accel_in + trim_r;
         vel_nxt = incr_vel_in + trim_to_vel(trim_r);
         take_nxt = (rcnt_r == RCNT_W'(RATE_DIV - 1));
         rcnt_nxt = take_nxt ? '0 : rcnt_r + 1'b1;
      end
      if (mode_r == MODE_TRIM || mode_r == MODE_SERVICE) begin
         if (trim_clear_in) begin
            trim_nxt = '0;
         end else if (trim_write_in) begin
            trim_nxt = trim_value_in;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sdiv_r <= '0;
         rcnt_r <= '0;
         smp_r <= 1'b0;
         take_r <= 1'b0;
         cnt_r <= CNT_RESET;
         acc_r <= '0;
         vel_r <= '0;
         trim_r <= '0;
      end else begin
         sdiv_r <= sdiv_nxt;
         rcnt_r <= rcnt_nxt;
         smp_r <= smp_nxt;
         take_r <= take_nxt;
         cnt_r <= cnt_nxt;
         acc_r <= acc_nxt;
         vel_r <= vel_nxt;
         trim_r <= trim_nxt;
      end
   end

   assign acc.smp = smp_r;
   assign acc.take = take_r;
   assign acc.acc_val = acc_r;
   assign acc.vel_val = vel_r;
   // Power-of-two window makes the mean a plain arithmetic shift
   assign avg = acc.acc_sum >>> LOG2_RATE;

   // Field formatting; fields refresh in the background in every mode
   always_comb begin
      incl_nxt = incl_r;
      temp_nxt = temp_r;
      lat_nxt = lat_r;
      dg_nxt = 1'b0;
      shot_nxt = 1'b0;
      if (acc.done) begin
         case (unit_sel_in)
            UNIT_ACCEL: incl_nxt = acc_r;
            UNIT_INCR: incl_nxt = acc.vel_sum[INCL_W-1:0];
            UNIT_AVG: incl_nxt = avg[INCL_W-1:0];
            UNIT_INTEG: incl_nxt = acc.vel_int;
            default: incl_nxt = ZERO_FIELD;
         endcase
         temp_nxt = temp_in;
         lat_nxt = latency_in;
         // Service and trim modes drop results instead of sending
         dg_nxt = (mode_r == MODE_NORMAL);
      end
      if (mode_r == MODE_SERVICE && single_shot_in) begin
         shot_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         incl_r <= ZERO_FIELD;
         temp_r <= '0;
         lat_r <= '0;
         dg_r <= 1'b0;
         shot_r <= 1'b0;
      end else begin
         incl_r <= incl_nxt;
         temp_r <= temp_nxt;
         lat_r <= lat_nxt;
         dg_r <= dg_nxt;
         shot_r <= shot_nxt;
      end
   end

   assign incl_field_out = incl_r;
   assign temp_field_out = temp_r;
   assign latency_field_out = lat_r;
   assign counter_out = cnt_r;
   assign datagram_valid_out = dg_r;
   assign shot_valid_out = shot_r;
   assign mode_out = mode_r;
   assign info_reply_out = info_r;
   assign trim_ack_out = ack_r;
   assign cfg_reload_out = reload_r;
endmodule : imu_format_core

// ==== tb/host_link_model.sv ====
// Host side: decoded commands delivered as one-cycle pulses
`timescale 1ns/1ns
module host_link_model (
   // Clock
   input wire logic core_clk_in,
   // Decoded command pulses and exit qualifier
   output logic [6:0] cmd_out,
   output logic exit_normal_out
);
   initial cmd_out = 7'h00;
   initial exit_normal_out = 1'b0;
   // A command only counts once its terminating carriage return arrives,
   // so each one reaches the device as a single whole pulse
   task send(input int idx, input logic to_normal);
      @(negedge core_clk_in);
      exit_normal_out = to_normal;
      cmd_out[idx] = 1'b1;
      @(negedge core_clk_in);
      cmd_out[idx] = 1'b0;
   endtask : send
endmodule : host_link_model

// ==== tb/imu_format_monitor.sv ====
// Concurrent checks on mode control and datagram pacing
`timescale 1ns/1ns
module imu_format_monitor
   import imu_fmt_pkg::*;
#(
   parameter int SAMPLE_DIV = 8,
   parameter int RATE_DIV = 4,
   parameter int INIT_CNT = 4
) (
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic trim_mode_entry_command_in,
   input wire logic trim_mode_exit_in,
   input wire logic maintenance_entry_command_in,
   input wire logic service_exit_in,
   input wire logic service_exit_normal_in,
   input wire logic single_shot_in,
   input wire logic [CNT_W-1:0] counter_out,
   input wire logic datagram_valid_out,
   input wire logic shot_valid_out,
   input wire logic [3:0] mode_out,
   input wire logic info_reply_out,
   input wire logic trim_ack_out,
   input wire logic cfg_reload_out
);
   // Slack of a few cycles over the init count for reaching normal mode
   localparam int INIT_LIM = INIT_CNT + 3;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence to_init_s;
      mode_out == MODE_INIT ##1 cfg_reload_out;
   endsequence
   sequence reach_norm_s;
      1'b1 ##[1:INIT_LIM] mode_out == MODE_NORMAL;
   endsequence
   svc_entry_a:
      assert property (maintenance_entry_command_in &&
         mode_out == MODE_NORMAL |=> mode_out == MODE_SERVICE &&
         info_reply_out) else $error("service entry not answered");
   trim_entry_a:
      assert property (trim_mode_entry_command_in &&
         !maintenance_entry_command_in && mode_out == MODE_NORMAL |=>
         mode_out == MODE_TRIM && trim_ack_out) else $error("no trim ack");
   trim_exit_a:
      assert property (trim_mode_exit_in && mode_out == MODE_TRIM |=>
         mode_out == MODE_NORMAL) else $error("trim exit failed");
   exit_normal_a:
      assert property (service_exit_in && service_exit_normal_in &&
         mode_out == MODE_SERVICE |=> mode_out == MODE_NORMAL)
         else $error("service exit to normal failed");
   exit_init_a:
      assert property (service_exit_in && !service_exit_normal_in &&
         mode_out == MODE_SERVICE |=> to_init_s ##0 reach_norm_s)
         else $error("service exit to init failed");
   reset_init_a:
      assert property ($rose(reset_n_in) |-> to_init_s ##0 reach_norm_s)
         else $error("reset did not pass through init");
   quiet_mode_a:
      assert property ((mode_out != MODE_NORMAL) [*4] |->
         !datagram_valid_out) else $error("datagram outside normal");
   single_shot_a:
      assert property (single_shot_in && mode_out == MODE_SERVICE |=>
         shot_valid_out) else $error("single shot not answered");
   counter_step_a:
      assert property ($changed(counter_out) |->
         counter_out == 8'($past(counter_out) + 8'h01))
         else $error("counter stepped wrongly");
   dgram_space_a:
      assert property (datagram_valid_out |=> !datagram_valid_out [*8])
         else $error("datagrams too close");
endmodule : imu_format_monitor

bind imu_format_core imu_format_monitor #(.SAMPLE_DIV(SAMPLE_DIV),
   .RATE_DIV(RATE_DIV), .INIT_CNT(INIT_CNT)) i_imu_format_monitor (
   .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
   .trim_mode_entry_command_in(trim_mode_entry_command_in),
   .trim_mode_exit_in(trim_mode_exit_in),
   .maintenance_entry_command_in(maintenance_entry_command_in),
   .service_exit_in(service_exit_in),
   .service_exit_normal_in(service_exit_normal_in),
   .single_shot_in(single_shot_in), .counter_out(counter_out),
   .datagram_valid_out(datagram_valid_out),
   .shot_valid_out(shot_valid_out), .mode_out(mode_out),
   .info_reply_out(info_reply_out), .trim_ack_out(trim_ack_out),
   .cfg_reload_out(cfg_reload_out));

// ==== tb/test_imu_output_format_mode_control.sv ====
// Self-checking bench for the formatter and mode control
`timescale 1ns/1ns
module test_imu_output_format_mode_control;
   import imu_fmt_pkg::*;
   logic core_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic signed [23:0] accel_in = 24'h012345;
   logic signed [23:0] incr_vel_in = 24'h000100;
   logic signed [15:0] temp_in = 16'hfe80;
   logic [15:0] latency_in = 16'h04d2;
   logic [1:0] unit_sel_in = UNIT_INCR;
   logic signed [23:0] trim_value_in = 24'h000000;
   logic [6:0] cmd;
   logic exit_normal;
   logic [23:0] incl_field_out;
   logic [15:0] temp_field_out;
   logic [15:0] latency_field_out;
   logic [7:0] counter_out;
   logic datagram_valid_out;
   logic shot_valid_out;
   logic [3:0] mode_out;
   int n_fail = 0;
   int tests_run = 0;
   initial forever #4 core_clk_in = ~core_clk_in;
   host_link_model i_host_link_model (.core_clk_in(core_clk_in),
      .cmd_out(cmd), .exit_normal_out(exit_normal));
   // Short sample and init counts keep the run brief
   imu_format_core #(.SAMPLE_DIV(8), .RATE_DIV(4), .INIT_CNT(4))
   i_imu_format_core (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .accel_in(accel_in), .incr_vel_in(incr_vel_in), .temp_in(temp_in),
      .latency_in(latency_in), .unit_sel_in(unit_sel_in),
      .trim_mode_entry_command_in(cmd[0]), .trim_mode_exit_in(cmd[1]),
      .maintenance_entry_command_in(cmd[2]), .service_exit_in(cmd[3]),
      .service_exit_normal_in(exit_normal), .single_shot_in(cmd[4]),
      .trim_write_in(cmd[5]), .trim_clear_in(cmd[6]),
      .trim_value_in(trim_value_in), .incl_field_out(incl_field_out),
      .temp_field_out(temp_field_out),
      .latency_field_out(latency_field_out), .counter_out(counter_out),
      .datagram_valid_out(datagram_valid_out),
      .shot_valid_out(shot_valid_out), .mode_out(mode_out),
      .info_reply_out(), .trim_ack_out(), .cfg_reload_out());
   task conclude;
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude
   task chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wait_dg;
      int i;
      i = 0;
      do begin
         @(negedge core_clk_in);
         i++;
      end while (datagram_valid_out !== 1'b1 && i < 100);
      chk(i < 100, 1'b1);
      if (i >= 100) conclude;
   endtask : wait_dg
   task wait_mode(input mode_type m);
      int i;
      for (i = 0; i < 200 && mode_out !== m; i++) @(negedge core_clk_in);
      chk(mode_out, m);
      if (mode_out !== m) conclude;
   endtask : wait_mode
   task t_fields;
      logic [7:0] c0;
      wait_dg;
      wait_dg;
      chk(incl_field_out, 24'h000400);
      c0 = counter_out;
      unit_sel_in = UNIT_AVG;
      wait_dg;
      wait_dg;
      chk(incl_field_out, 24'h012345);
      chk(counter_out, 8'(c0 + 8'h08));
      unit_sel_in = UNIT_ACCEL;
      wait_dg;
      wait_dg;
      chk(incl_field_out, 24'h012345);
      chk(temp_field_out, 16'hfe80);
      chk(latency_field_out, 16'h04d2);
   endtask : t_fields
   task t_trim;
      logic [23:0] v0;
      i_host_link_model.send(0, 1'b0);
      chk(mode_out, MODE_TRIM);
      // Trim of 2^16 counts in g gives exactly the Q16 factor per sample
      trim_value_in = 24'h010000;
      i_host_link_model.send(5, 1'b0);
      i_host_link_model.send(1, 1'b0);
      wait_dg;
      wait_dg;
      chk(incl_field_out, 24'h022345);
      unit_sel_in = UNIT_INCR;
      wait_dg;
      wait_dg;
      chk(incl_field_out, 24'(4 * (256 + TRIM_VEL_Q16)));
      unit_sel_in = UNIT_ACCEL;
      i_host_link_model.send(0, 1'b0);
      i_host_link_model.send(6, 1'b0);
      i_host_link_model.send(1, 1'b0);
      wait_dg;
      wait_dg;
      chk(incl_field_out, 24'h012345);
      // Integral grows by four untrimmed increments per datagram
      unit_sel_in = UNIT_INTEG;
      wait_dg;
      wait_dg;
      v0 = incl_field_out;
      wait_dg;
      chk(incl_field_out, 24'(v0 + 24'h000400));
   endtask : t_trim
   task t_service;
      int n;
      n = 0;
      i_host_link_model.send(2, 1'b0);
      wait_mode(MODE_SERVICE);
      repeat (80) begin
         @(negedge core_clk_in);
         if (datagram_valid_out !== 1'b0) n++;
      end
      chk(24'(n), 24'h000000);
      i_host_link_model.send(4, 1'b0);
      chk(shot_valid_out, 1'b1);
      i_host_link_model.send(3, 1'b1);
      wait_mode(MODE_NORMAL);
      i_host_link_model.send(2, 1'b0);
      wait_mode(MODE_SERVICE);
      i_host_link_model.send(3, 1'b0);
      chk(mode_out, MODE_INIT);
      wait_mode(MODE_NORMAL);
      i_host_link_model.send(2, 1'b0);
      wait_mode(MODE_SERVICE);
      reset_n_in = 1'b0;
      @(negedge core_clk_in);
      chk(mode_out, MODE_INIT);
      chk(counter_out, 8'h00);
      reset_n_in = 1'b1;
      wait_mode(MODE_NORMAL);
   endtask : t_service
   initial begin
      repeat (8) @(negedge core_clk_in);
      reset_n_in = 1'b1;
      wait_mode(MODE_NORMAL);
      t_fields;
      t_trim;
      t_service;
      conclude;
   end
endmodule : test_imu_output_format_mode_control
